// file: design/amprb_pkg.sv
// Constants, register map and timing for the amplifier control register bank
// What this block does
// - Writing one to soft reset bit resets every register like power-on; bit self-clears.
// - Read is 0x80 plus address then dummy; write is 0x40 plus address then data.
// - Polarity bit n sets SPI mode of chip-select output n when enabled.
// - Polarity one selects mode 1 rising edge; zero selects mode 2 falling edge.
// - Timeout field counts on-time in steps of four device clock periods.
// - Timeout field zero keeps the transient buffer from starting; a running buffer finishes its count.
// - Shortest buffer on-time is about six microseconds for small nonzero values.
// - Timeout field resets to the value giving one hundred microseconds.
// - Error bit 5 shows live whether the transient buffer is active.
// - Error flags set on detection and clear only by writing one or by soft reset.
// - Checksum error flag bit 7 works only in checksum mode, sets on mismatch.
// - Error bits: saturation 6, clamp 4, output stage 2, gain 1, overvoltage 0.
// - Error bit 3 is OR of enabled errors except checksum bit 7, routable to pin 3.
// - Output stage error asserts only after condition persists about six microseconds.
// - Pin data bits map to pins; reads sample inputs, return stored outputs.
// - Switch register one closes switches on one; only A-path switches after reset.
// - Switch register two drives four switches from bits 3 to 0.
// - Direction bit zero is input, one is output; all inputs after reset.
// - Chip-select enable bits give pins the extended chip-select function.
// - Special function beats extended chip select, which beats plain pin data.
// - Extended chip select acts only when enable bit and direction output.
// - Blank register bits ignore writes and read back as zero.
package amprb_pkg;
    // Register addresses
    localparam logic [3:0] ADDR_SOFT_RESET = 4'h1;
    localparam logic [3:0] ADDR_CLK_POL = 4'h2;
    localparam logic [3:0] ADDR_BUF_TIMEOUT = 4'h3;
    localparam logic [3:0] ADDR_ERROR = 4'h4;
    localparam logic [3:0] ADDR_PIN_DATA = 4'h5;
    localparam logic [3:0] ADDR_SWITCH_ONE = 4'h6;
    localparam logic [3:0] ADDR_SWITCH_TWO = 4'h7;
    localparam logic [3:0] ADDR_PIN_DIR = 4'h8;
    localparam logic [3:0] ADDR_CS_ENABLE = 4'h9;
    // Command byte encodings
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    // Writable bit masks
    localparam logic [7:0] MASK_SEVEN = 8'h7F;
    localparam logic [7:0] MASK_TIMEOUT = 8'h3F;
    localparam logic [7:0] MASK_SWITCH_TWO = 8'h0F;
    localparam logic [7:0] MASK_ERR_W1C = 8'hD7;
    // Reset values
    localparam logic [5:0] RST_TIMEOUT = 6'h19;
    localparam logic [6:0] RST_SWITCH_ONE = 7'h60;
    // Error bit positions
    localparam int ERR_CHK = 7;
    localparam int ERR_SAT = 6;
    localparam int ERR_BUF = 5;
    localparam int ERR_CLAMP = 4;
    localparam int ERR_SUM = 3;
    localparam int ERR_OUT = 2;
    localparam int ERR_GAIN = 1;
    localparam int ERR_OV = 0;
    localparam int PIN_EF = 3;
    localparam int SF_EF = 3;
    // Timing
    localparam int CORE_CLK_PERIOD_NS = 25;
    localparam int DEV_CLK_PERIOD_NS = 1000;
    localparam int DEV_TICK_CYCLES = DEV_CLK_PERIOD_NS / CORE_CLK_PERIOD_NS;
    localparam int TIMEOUT_STEP_TICKS = 4;
    localparam int BUF_MIN_TIME_NS = 6000;
    localparam int BUF_MIN_TICKS = (BUF_MIN_TIME_NS + DEV_CLK_PERIOD_NS - 1) / DEV_CLK_PERIOD_NS;
    localparam int OUT_DELAY_NS = 6000;
    localparam int OUT_DELAY_CYCLES =
        (OUT_DELAY_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int FRAME_CMD_BITS = 8;
    localparam int FRAME_BITS = 16;
endpackage

// file: design/amprb_regbank.sv
// SPI-reached control and status register bank of the amplifier
`timescale 1ns/10ps
module amprb_regbank
    import amprb_pkg::*;
(
    // Core clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // SPI link
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe,
    // Status and control from the rest of the device
    input wire logic i_checksum_enable_bit,
    input wire logic i_checksum_mismatch,
    input wire logic i_buffer_start,
    input wire logic [7:0] i_error_disable,
    input wire logic [7:0] i_special_function,
    input wire logic [4:0] i_fault_cond,
    // Multi-function pins
    input wire logic [6:0] i_multi_function_pin,
    output logic [6:0] o_multi_function_pin,
    output logic [6:0] o_multi_function_pin_oe,
    // Block outputs
    output logic o_soft_reset,
    output logic o_buffer_active_flag,
    output logic o_error_summary_flag,
    output logic [6:0] o_input_switch_one,
    output logic [3:0] o_input_switch_two,
    output logic [6:0] o_extended_chip_select,
    output logic [6:0] o_ecs_mode_one
);

    // ----------------------------------------
    // Link domain: SPI shifter
    // ----------------------------------------
    logic spi_rst_n;
    logic [4:0] bit_cnt_q;
    logic [7:0] cmd_q;
    logic [6:0] shift_q;
    logic [3:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_tog_q;
    logic rd_tog_q;
    logic sdo_q;
    logic [7:0] rd_word_q;

    // Frame logic is cleared by CS high, so a stopped clock leaves no state behind
    assign spi_rst_n = i_arst_n & ~i_spi_cs_n;

    always_ff @(negedge i_spi_sclk or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            bit_cnt_q <= 5'h00;
            shift_q <= 7'h00;
            cmd_q <= 8'h00;
        end
        else
        begin
            if (bit_cnt_q != 5'(FRAME_BITS))
            begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            shift_q <= {shift_q[5:0], i_spi_sdi};
            if (bit_cnt_q == 5'(FRAME_CMD_BITS - 1))
            begin
                cmd_q <= {shift_q, i_spi_sdi};
            end
        end
    end

    // Write and read requests cross by toggle; data held stable until next frame
    always_ff @(negedge i_spi_sclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_tog_q <= 1'b0;
            rd_tog_q <= 1'b0;
            wr_addr_q <= 4'h0;
            wr_data_q <= 8'h00;
        end
        else if (!i_spi_cs_n)
        begin
            if (bit_cnt_q == 5'(FRAME_CMD_BITS - 1) && shift_q[6:5] == CMD_READ)
            begin
                wr_addr_q <= {shift_q[2:0], i_spi_sdi};
                rd_tog_q <= ~rd_tog_q;
            end
            if (bit_cnt_q == 5'(FRAME_BITS - 1) && cmd_q[7:6] == CMD_WRITE)
            begin
                wr_addr_q <= cmd_q[3:0];
                wr_data_q <= {shift_q, i_spi_sdi};
                wr_tog_q <= ~wr_tog_q;
            end
        end
    end

    always_ff @(posedge i_spi_sclk or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            sdo_q <= 1'b0;
        end
        else if (bit_cnt_q >= 5'(FRAME_CMD_BITS) && bit_cnt_q < 5'(FRAME_BITS))
        begin
            sdo_q <= rd_word_q[~bit_cnt_q[2:0]];
        end
    end

    assign o_spi_sdo = sdo_q;
    assign o_spi_sdo_oe = ~i_spi_cs_n;

    // ----------------------------------------
    // Core domain: crossings and synchronisers
    // ----------------------------------------
    logic [2:0] wr_sync_q;
    logic [2:0] rd_sync_q;
    logic wr_evt;
    logic rd_evt;
    logic [6:0] pin_meta_q;
    logic [6:0] pin_sync_q;
    logic [4:0] fault_meta_q;
    logic [4:0] fault_sync_q;
    logic cs_meta_q;
    logic cs_sync_q;

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_sync_q <= 3'h0;
            rd_sync_q <= 3'h0;
            pin_meta_q <= 7'h00;
            pin_sync_q <= 7'h00;
            fault_meta_q <= 5'h00;
            fault_sync_q <= 5'h00;
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
        end
        else
        begin
            wr_sync_q <= {wr_sync_q[1:0], wr_tog_q};
            rd_sync_q <= {rd_sync_q[1:0], rd_tog_q};
            pin_meta_q <= i_multi_function_pin;
            pin_sync_q <= pin_meta_q;
            fault_meta_q <= i_fault_cond;
            fault_sync_q <= fault_meta_q;
            cs_meta_q <= i_spi_cs_n;
            cs_sync_q <= cs_meta_q;
        end
    end

    // Edge detection looks only at the second and third stages
    assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
    assign rd_evt = rd_sync_q[2] ^ rd_sync_q[1];

    // ----------------------------------------
    // Core domain: registers
    // ----------------------------------------
    logic soft_rst_q;
    logic [6:0] clk_pol_q;
    logic [5:0] timeout_q;
    logic [7:0] err_q;
    logic [6:0] pin_data_q;
    logic [6:0] sw_one_q;
    logic [3:0] sw_two_q;
    logic [6:0] dir_q;
    logic [6:0] cs_en_q;
    logic buf_active_q;
    logic ef_live;
    logic [7:0] err_view;
    logic [6:0] pin_view;

    function automatic logic wr_hit(input logic evt, input logic [3:0] a, input logic [3:0] r);
        wr_hit = evt && (a == r);
    endfunction

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            soft_rst_q <= 1'b0;
        end
        else
        begin
            soft_rst_q <= wr_hit(wr_evt, wr_addr_q, ADDR_SOFT_RESET) & wr_data_q[0];
        end
    end

    assign o_soft_reset = soft_rst_q;

    // soft reset returns all settings to defaults
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            clk_pol_q <= 7'h00;
            timeout_q <= RST_TIMEOUT;
            pin_data_q <= 7'h00;
            sw_one_q <= RST_SWITCH_ONE;
            sw_two_q <= 4'h0;
            dir_q <= 7'h00;
            cs_en_q <= 7'h00;
        end
        else if (soft_rst_q)
        begin
            clk_pol_q <= 7'h00;
            timeout_q <= RST_TIMEOUT;
            pin_data_q <= 7'h00;
            sw_one_q <= RST_SWITCH_ONE;
            sw_two_q <= 4'h0;
            dir_q <= 7'h00;
            cs_en_q <= 7'h00;
        end
        else
        begin
            if (wr_hit(wr_evt, wr_addr_q, ADDR_CLK_POL))
                clk_pol_q <= wr_data_q[6:0];
            if (wr_hit(wr_evt, wr_addr_q, ADDR_BUF_TIMEOUT))
                timeout_q <= wr_data_q[5:0];
            if (wr_hit(wr_evt, wr_addr_q, ADDR_PIN_DATA))
                pin_data_q <= wr_data_q[6:0];
            if (wr_hit(wr_evt, wr_addr_q, ADDR_SWITCH_ONE))
                sw_one_q <= wr_data_q[6:0];
            if (wr_hit(wr_evt, wr_addr_q, ADDR_SWITCH_TWO))
                sw_two_q <= wr_data_q[3:0];
            if (wr_hit(wr_evt, wr_addr_q, ADDR_PIN_DIR))
                dir_q <= wr_data_q[6:0];
            if (wr_hit(wr_evt, wr_addr_q, ADDR_CS_ENABLE))
                cs_en_q <= wr_data_q[6:0];
        end
    end

    assign o_input_switch_one = sw_one_q;
    assign o_input_switch_two = sw_two_q;

    // ----------------------------------------
    // Transient buffer timer
    // ----------------------------------------
    logic [5:0] tick_cnt_q;
    logic dev_tick;
    logic [7:0] buf_cnt_q;
    logic [7:0] buf_load;

    assign dev_tick = (tick_cnt_q == 6'(DEV_TICK_CYCLES - 1));

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            tick_cnt_q <= 6'h00;
        else if (dev_tick)
            tick_cnt_q <= 6'h00;
        else
            tick_cnt_q <= tick_cnt_q + 6'h01;
    end

    assign buf_load = ({timeout_q, 2'b00} < 8'(BUF_MIN_TICKS)) ? 8'(BUF_MIN_TICKS)
                                                               : {timeout_q, 2'b00};

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            buf_cnt_q <= 8'h00;
            buf_active_q <= 1'b0;
        end
        else if (soft_rst_q)
        begin
            buf_cnt_q <= 8'h00;
            buf_active_q <= 1'b0;
        end
        else if (i_buffer_start && timeout_q != 6'h00)
        begin
            buf_cnt_q <= buf_load;
            buf_active_q <= 1'b1;
        end
        else if (buf_active_q && dev_tick)
        begin
            buf_cnt_q <= buf_cnt_q - 8'h01;
            if (buf_cnt_q == 8'h01)
                buf_active_q <= 1'b0;
        end
    end

    assign o_buffer_active_flag = buf_active_q;

    // ----------------------------------------
    // Error flags
    // ----------------------------------------
    logic [8:0] out_cnt_q;
    logic out_err_det;
    logic [7:0] err_set;
    logic [7:0] err_clr;

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            out_cnt_q <= 9'h000;
        else if (!fault_sync_q[2])
            out_cnt_q <= 9'h000;
        else if (out_cnt_q != 9'(OUT_DELAY_CYCLES))
            out_cnt_q <= out_cnt_q + 9'h001;
    end

    assign out_err_det = (out_cnt_q == 9'(OUT_DELAY_CYCLES));

    always_comb
    begin
        err_set = 8'h00;
        // checksum error only in checksum mode
        err_set[ERR_CHK] = i_checksum_enable_bit & i_checksum_mismatch;
        err_set[ERR_SAT] = fault_sync_q[4];
        err_set[ERR_CLAMP] = fault_sync_q[3];
        err_set[ERR_OUT] = out_err_det;
        err_set[ERR_GAIN] = fault_sync_q[1];
        err_set[ERR_OV] = fault_sync_q[0];
        err_clr = wr_hit(wr_evt, wr_addr_q, ADDR_ERROR) ? (wr_data_q & MASK_ERR_W1C) : 8'h00;
    end

    // sticky flags, set wins over clear
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            err_q <= 8'h00;
        else if (soft_rst_q)
            err_q <= 8'h00;
        else
            err_q <= (err_q & ~err_clr) | err_set;
    end

    assign ef_live = |(err_q & MASK_ERR_W1C & ~i_error_disable & ~(8'h01 << ERR_CHK));
    assign o_error_summary_flag = ef_live;

    always_comb
    begin
        err_view = err_q;
        err_view[ERR_BUF] = buf_active_q;
        err_view[ERR_SUM] = ef_live;
    end

    // ----------------------------------------
    // Pins and read-back
    // ----------------------------------------
    logic [6:0] ecs_act;

    // inputs sampled, outputs read back stored value
    assign pin_view = (dir_q & pin_data_q) | (~dir_q & pin_sync_q);

    // enable and output direction both needed
    assign ecs_act = cs_en_q & dir_q;
    assign o_extended_chip_select = ecs_act;
    // polarity only on active chip selects
    assign o_ecs_mode_one = clk_pol_q & ecs_act;
    assign o_multi_function_pin_oe = dir_q;

    // special function over chip select over data
    always_comb
    begin
        for (int i = 0; i < 7; i++)
        begin
            if (ecs_act[i])
                o_multi_function_pin[i] = cs_sync_q;
            else
                o_multi_function_pin[i] = pin_data_q[i];
        end
        if (i_special_function[SF_EF] && dir_q[PIN_EF])
            o_multi_function_pin[PIN_EF] = ef_live;
    end

    function automatic logic [7:0] reg_read(input logic [3:0] a);
        unique case (a)
            ADDR_CLK_POL: reg_read = {1'b0, clk_pol_q};
            ADDR_BUF_TIMEOUT: reg_read = {2'b00, timeout_q};
            ADDR_ERROR: reg_read = err_view;
            ADDR_PIN_DATA: reg_read = {1'b0, pin_view};
            ADDR_SWITCH_ONE: reg_read = {1'b0, sw_one_q};
            ADDR_SWITCH_TWO: reg_read = {4'h0, sw_two_q};
            ADDR_PIN_DIR: reg_read = {1'b0, dir_q};
            ADDR_CS_ENABLE: reg_read = {1'b0, cs_en_q};
            default: reg_read = 8'h00;
        endcase
    endfunction

    // Read word is frozen before the second byte; host must leave a gap after the command
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rd_word_q <= 8'h00;
        else if (rd_evt)
            rd_word_q <= reg_read(wr_addr_q);
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_soft_write;
        wr_evt && wr_addr_q == ADDR_SOFT_RESET && wr_data_q[0];
    endsequence

    a_soft_reset_defaults: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        s_soft_write ##2 1'b1 |-> timeout_q == RST_TIMEOUT && dir_q == 7'h00)
        else $error("soft reset did not restore defaults");

    a_soft_bit_clears: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        soft_rst_q |=> !soft_rst_q || $past(wr_evt))
        else $error("soft reset pulse stuck");

    a_buffer_zero_off: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        timeout_q == 6'h00 && !buf_active_q |=> !buf_active_q)
        else $error("buffer started with zero timeout");

    a_buffer_min_time: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        i_buffer_start && timeout_q != 6'h00 && !soft_rst_q |=> buf_cnt_q >= 8'(BUF_MIN_TICKS))
        else $error("buffer on-time below floor");

    a_buffer_step_load: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        i_buffer_start && timeout_q > 6'h01 && !soft_rst_q |=>
            buf_cnt_q == 8'($past(timeout_q)) * 8'(TIMEOUT_STEP_TICKS))
        else $error("buffer load mismatch");

    a_set_beats_clear: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        fault_sync_q[0] && !soft_rst_q |=> err_q[ERR_OV])
        else $error("overvoltage flag lost");

    a_flag_holds: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        err_q[ERR_GAIN] && !err_clr[ERR_GAIN] && !soft_rst_q |=> err_q[ERR_GAIN])
        else $error("gain flag dropped without clear");

    a_checksum_gate: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        !err_q[ERR_CHK] && !i_checksum_enable_bit |=> !err_q[ERR_CHK])
        else $error("checksum flag set outside checksum mode");

    a_out_delay: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        $rose(fault_sync_q[2]) |-> !out_err_det [*8])
        else $error("output stage error without delay");

    a_ecs_needs_dir: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        (cs_en_q & ~dir_q) != 7'h00 |->
            ((cs_en_q & ~dir_q) & (o_multi_function_pin ^ pin_data_q)) == 7'h00)
        else $error("chip select on an input pin");

    a_ecs_drives_pin: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        !i_special_function[SF_EF] |->
            (o_extended_chip_select & (o_multi_function_pin ^ {7{cs_sync_q}})) == 7'h00)
        else $error("chip select pin not driven by select");

    a_pin_readback: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        rd_evt && wr_addr_q == ADDR_PIN_DATA |=> rd_word_q[6:0] == $past(pin_view))
        else $error("pin data read-back wrong");

endmodule

// file: tb/amprb_spi_host.sv
// SPI host model issuing register frames
`timescale 1ns/10ps
module amprb_spi_host (
    // SPI lines
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end
    task automatic xfer(input logic [15:0] f, output logic [7:0] q);
        o_cs_n = 1'b0;
        #20;
        for (int i = 15; i >= 0; i--)
        begin
            #3 o_sdi = f[i];
            #3 o_sclk = 1'b1;
            #6 o_sclk = 1'b0;
            if (i < 8)
                q[i] = i_sdo;
            // Device fetches the read word in this gap
            if (i == 8)
                #250;
        end
        #10 o_cs_n = 1'b1;
        // Released line shows the inverse, never stale data
        o_sdi = ~o_sdi;
        #250;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer({4'h4, a, d}, q);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        xfer({4'h8, a, 8'h00}, q);
    endtask
endmodule

// file: tb/amprb_regbank_tb_top.sv
// Self-checking bench for the amplifier register bank
`timescale 1ns/10ps
module amprb_regbank_tb_top
    import amprb_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sclk, cs_n, sdi, sdo, sdo_oe, chk_en, chk_bad, buf_go, srst, buf_act, ef;
    logic [7:0] err_dis, sf;
    logic [4:0] fault;
    logic [6:0] pin_i, pin_o, pin_oe, sw1, extended_chip_select, ecs_m1;
    logic [3:0] sw2;
    wire sdo_w;
    int mismatches = 0;
    int n_tests = 0;
    int act_cnt = 0;
    int srst_cnt = 0;
    assign sdo_w = sdo_oe ? sdo : 1'bz;
    always #12.5 clk = ~clk;
    // Sampled half a cycle off the launching edge
    always @(negedge clk)
    begin
        if (buf_act === 1'b1)
            act_cnt++;
        if (srst === 1'b1)
            srst_cnt++;
    end
    amprb_spi_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_w));
    amprb_regbank dut (
        .i_core_clk(clk), .i_arst_n(arst_n), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
        .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe),
        .i_checksum_enable_bit(chk_en), .i_checksum_mismatch(chk_bad),
        .i_buffer_start(buf_go), .i_error_disable(err_dis), .i_special_function(sf),
        .i_fault_cond(fault), .i_multi_function_pin(pin_i), .o_multi_function_pin(pin_o),
        .o_multi_function_pin_oe(pin_oe), .o_soft_reset(srst),
        .o_buffer_active_flag(buf_act), .o_error_summary_flag(ef),
        .o_input_switch_one(sw1), .o_input_switch_two(sw2),
        .o_extended_chip_select(extended_chip_select), .o_ecs_mode_one(ecs_m1));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host.rd(a, q);
        chk(q, exp);
    endtask
    task automatic wrap_up;
        $display("Counts: %0d checks, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic t_reset;
        rchk(ADDR_CLK_POL, 8'h00);
        rchk(ADDR_BUF_TIMEOUT, 8'h19);
        rchk(ADDR_ERROR, 8'h00);
        rchk(ADDR_PIN_DATA, 8'h00);
        rchk(ADDR_SWITCH_ONE, 8'h60);
        rchk(ADDR_PIN_DIR, 8'h00);
        rchk(ADDR_CS_ENABLE, 8'h00);
        rchk(4'hF, 8'h00);
        chk({1'b0, sw1}, 8'h60);
        chk({1'b0, pin_oe}, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_mask;
        logic [3:0] a [6] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9};
        logic [7:0] m [6] = '{8'h7F, 8'h3F, 8'h7F, 8'h0F, 8'h7F, 8'h7F};
        for (int k = 0; k < 6; k++)
        begin
            host.wr(a[k], 8'hFF);
            rchk(a[k], m[k]);
        end
        chk({4'h0, sw2}, 8'h0F);
        chk({1'b0, extended_chip_select}, 8'h7F);
        host.wr(ADDR_SOFT_RESET, 8'h01);
        rchk(ADDR_CS_ENABLE, 8'h00);
        rchk(ADDR_BUF_TIMEOUT, 8'h19);
        chk(8'(srst_cnt), 8'h01);
        chk({1'b0, sw1}, 8'h60);
        chk({1'b0, pin_oe}, 8'h00);
        $display("t_mask done");
    endtask
    task automatic t_pins;
        host.wr(ADDR_PIN_DIR, 8'h0F);
        host.wr(ADDR_CS_ENABLE, 8'h13);
        host.wr(ADDR_CLK_POL, 8'h01);
        host.wr(ADDR_PIN_DATA, 8'h76);
        @(negedge clk);
        pin_i = 7'h55;
        chk({1'b0, extended_chip_select}, 8'h03);
        chk({6'h00, ecs_m1[1:0]}, 8'h01);
        chk({1'b0, pin_o & 7'h0C}, 8'h04);
        chk({6'h00, pin_o[1:0]}, 8'h03);
        chk({7'h00, pin_o[4]}, 8'h01);
        rchk(ADDR_PIN_DATA, 8'h56);
        $display("t_pins done");
    endtask
    task automatic pulse(input logic [4:0] f, input int n);
        @(negedge clk);
        fault = f;
        repeat (n) @(negedge clk);
        fault = 5'h00;
    endtask
    task automatic t_err;
        sf = 8'h08;
        pulse(5'h02, 20);
        rchk(ADDR_ERROR, 8'h0A);
        host.wr(ADDR_ERROR, 8'h00);
        rchk(ADDR_ERROR, 8'h0A);
        chk({7'h00, pin_o[3]}, 8'h01);
        host.wr(ADDR_ERROR, 8'h02);
        rchk(ADDR_ERROR, 8'h00);
        chk({7'h00, pin_o[3]}, 8'h00);
        pulse(5'h04, 100);
        rchk(ADDR_ERROR, 8'h00);
        pulse(5'h04, 300);
        err_dis = 8'h04;
        rchk(ADDR_ERROR, 8'h04);
        chk({7'h00, ef}, 8'h00);
        host.wr(ADDR_ERROR, 8'h04);
        @(negedge clk);
        chk_bad = 1'b1;
        @(negedge clk);
        chk_bad = 1'b0;
        rchk(ADDR_ERROR, 8'h00);
        @(negedge clk);
        chk_en = 1'b1;
        chk_bad = 1'b1;
        @(negedge clk);
        chk_bad = 1'b0;
        rchk(ADDR_ERROR, 8'h80);
        host.wr(ADDR_ERROR, 8'h80);
        rchk(ADDR_ERROR, 8'h00);
        $display("t_err done");
    endtask
    task automatic t_buf;
        logic [7:0] v [3] = '{8'h02, 8'h01, 8'h00};
        int lo [3] = '{281, 201, 0};
        for (int k = 0; k < 3; k++)
        begin
            host.wr(ADDR_BUF_TIMEOUT, v[k]);
            @(negedge clk);
            act_cnt = 0;
            buf_go = 1'b1;
            @(negedge clk);
            buf_go = 1'b0;
            rchk(ADDR_ERROR, (k < 2) ? 8'h20 : 8'h00);
            repeat (500) @(negedge clk);
            // Up to one device tick of phase on the start
            chk(8'(act_cnt >= lo[k] && act_cnt <= lo[k] + (k < 2 ? 39 : 0)), 8'h01);
            rchk(ADDR_ERROR, 8'h00);
        end
        $display("t_buf done");
    endtask
    initial
    begin
        {chk_en, chk_bad, buf_go} = 3'h0;
        err_dis = 8'h00;
        sf = 8'h00;
        fault = 5'h00;
        pin_i = 7'h00;
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_mask();
        t_pins();
        t_err();
        t_buf();
        wrap_up();
    end
endmodule
